// [vsg_pkg.sv]
/*
  Shared constants and types of the video sync timing generator.
  Assumes one double-rate core clock; the pixel rate is derived inside.
*/
// Contract
// - Horizontal timing comes from 24 software-loaded timing registers at 10-15 Mpps.
// - Each element lasts its register count N of pixel periods, two core clocks each.
// - Horizontal edges move in steps of two core clock periods, never finer; in slave mode a sync pin fall restarts the sync interval on any core clock.
// - Vertical element lengths are also register counts of pixel periods.
// - A sync line holds two pulses, each a low part then a high part.
// - An equalization line holds two pulses; low plus high fills half a line.
// - First half-line segment equals half a line minus colour back porch.
// - Second half-line segment equals active video minus half a line.
// - Half-black lines put the extended back porch after burst, replacing colour back porch.
// - Four fields coded 0 to 3; fields 1, 3 end at 263, fields 2, 4 at 525.
// - Odd fields: 1-3 equalize, 4-6 sync, 7-9 equalize, 10-20 blank, 21-262 video, 263 half.
// - Even fields: 264-265 equalize, 266 ES, 267-268 sync, 269 SE, 270-271 equalize, 272 broad.
// - Even fields: 273-282 blank with burst, 283 half black half video, rest video.
// - Code 02 is half sync then half equalize; code 01 the reverse.
// - Code 0C is half active video then half equalization.
// - In slave mode sync pins are inputs; a falling edge starts the sync interval.
package vsg_pkg;
  // widths
  localparam int LEN_W = 12;
  localparam int NUM_TREG = 24;
  localparam int CODE_W = 5;
  localparam int LINE_W = 10;
  // timing register indices
  localparam int T_FP = 0;
  localparam int T_SY = 1;
  localparam int T_BR = 2;
  localparam int T_BU = 3;
  localparam int T_CBP = 4;
  localparam int T_VA = 5;
  localparam int T_SL = 6;
  localparam int T_SH = 7;
  localparam int T_EL = 8;
  localparam int T_EH = 9;
  localparam int T_VB = 10;
  localparam int T_VC = 11;
  localparam int T_XBP = 12;
  // apb byte offsets and control bits
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] TREG_BASE = 8'h08;
  localparam logic [7:0] TREG_END = 8'(TREG_BASE + 4 * NUM_TREG);
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SLAVE_BIT = 1;
  // line category codes
  localparam logic [CODE_W-1:0] LC_EQ = 5'h00;
  localparam logic [CODE_W-1:0] LC_ES = 5'h01;
  localparam logic [CODE_W-1:0] LC_SE = 5'h02;
  localparam logic [CODE_W-1:0] LC_SYNC = 5'h03;
  localparam logic [CODE_W-1:0] LC_VE = 5'h0C;
  localparam logic [CODE_W-1:0] LC_BB = 5'h0D;
  localparam logic [CODE_W-1:0] LC_BV = 5'h0E;
  localparam logic [CODE_W-1:0] LC_FV = 5'h0F;
  localparam logic [CODE_W-1:0] LC_EB = 5'h10;
  // first and last lines of the runs in the field pattern
  localparam logic [LINE_W-1:0] LN_FIRST = 10'h001;
  localparam logic [LINE_W-1:0] LN_EQ1_END = 10'h003;
  localparam logic [LINE_W-1:0] LN_VS_FIRST = 10'h004;
  localparam logic [LINE_W-1:0] LN_SY1_END = 10'h006;
  localparam logic [LINE_W-1:0] LN_EQ2_END = 10'h009;
  localparam logic [LINE_W-1:0] LN_BB1_END = 10'h014;
  localparam logic [LINE_W-1:0] LN_A_LAST = 10'h107;
  localparam logic [LINE_W-1:0] LN_EQ3_END = 10'h109;
  localparam logic [LINE_W-1:0] LN_ES = 10'h10A;
  localparam logic [LINE_W-1:0] LN_SY2_END = 10'h10C;
  localparam logic [LINE_W-1:0] LN_SE = 10'h10D;
  localparam logic [LINE_W-1:0] LN_EQ4_END = 10'h10F;
  localparam logic [LINE_W-1:0] LN_EB = 10'h110;
  localparam logic [LINE_W-1:0] LN_BB2_END = 10'h11A;
  localparam logic [LINE_W-1:0] LN_BV = 10'h11B;
  localparam logic [LINE_W-1:0] LN_B_LAST = 10'h20D;
  // element slots of one line
  typedef enum logic [7:0] {
    SLOT0 = 8'h01, SLOT1 = 8'h02, SLOT2 = 8'h04, SLOT3 = 8'h08,
    SLOT4 = 8'h10, SLOT5 = 8'h20, SLOT6 = 8'h40, SLOT7 = 8'h80
  } vsg_slot_t;
  typedef enum logic [2:0] {
    K_BLANK, K_HSYNC, K_BURST, K_VIDEO, K_EQLOW, K_VSLOW
  } vsg_kind_t;
  typedef struct packed {
    vsg_kind_t kind;
    logic [4:0] ridx;
    logic last;
  } vsg_seg_t;
  // line counter state
  typedef struct packed {
    logic [LINE_W-1:0] line;
    logic [1:0] field;
    logic [CODE_W-1:0] code;
  } vsg_seq_st_t;
  localparam vsg_seq_st_t SEQ_RST = '{line: LN_FIRST, field: 2'h0, code: LC_EQ};
endpackage

// [vsg_seq_if.sv]
/*
  Carrier between the element sequencer and the line/field counter.
  Assumes both ends share the core clock.
*/
`timescale 1ns/10ps
interface vsg_seq_if;
  logic adv;
  logic resync;
  logic [vsg_pkg::CODE_W-1:0] code;
  logic [1:0] field;
  logic [vsg_pkg::LINE_W-1:0] line;
  modport ctl (output adv, output resync, input code, input field, input line);
  modport seq (input adv, input resync, output code, output field, output line);
endinterface

// [vsg_pix_div.sv]
/*
  Pixel phase divider and sync pin edge finder.
  Assumes sync pin levels already synchronous to the core clock.
*/
`timescale 1ns/10ps
module vsg_pix_div (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sync pin levels
  input wire logic hs_n,
  input wire logic vs_n,
  // pixel phase and edges
  output logic tick,
  output logic hs_fall,
  output logic vs_fall
);
  typedef struct packed {
    logic tick;
    logic hs;
    logic vs;
  } vsg_div_st_t;

  vsg_div_st_t q;
  vsg_div_st_t d;

  // tick toggles so every pixel spans two core clocks
  always_comb begin
    d.tick = !q.tick;
    d.hs = hs_n;
    d.vs = vs_n;
  end

  // idle high so release from reset gives no false edge
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{tick: 1'h0, hs: 1'h1, vs: 1'h1};
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
  assign hs_fall = q.hs && !hs_n;
  assign vs_fall = q.vs && !vs_n;
endmodule

// [vsg_field_seq.sv]
/*
  Line and field counter with line category lookup.
  Assumes adv pulses once per line end and resync once per vertical edge.
*/
`timescale 1ns/10ps
module vsg_field_seq (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sequencer side
  vsg_seq_if.seq bus
);
  vsg_pkg::vsg_seq_st_t q;
  vsg_pkg::vsg_seq_st_t d;

  // category by line number alone; odd fields never pass line 263
  function automatic logic [vsg_pkg::CODE_W-1:0] code_of(input logic [vsg_pkg::LINE_W-1:0] n);
    logic [vsg_pkg::CODE_W-1:0] c;
    c = vsg_pkg::LC_FV;
    if (n <= vsg_pkg::LN_EQ1_END) c = vsg_pkg::LC_EQ;
    else if (n <= vsg_pkg::LN_SY1_END) c = vsg_pkg::LC_SYNC;
    else if (n <= vsg_pkg::LN_EQ2_END) c = vsg_pkg::LC_EQ;
    else if (n <= vsg_pkg::LN_BB1_END) c = vsg_pkg::LC_BB;
    else if (n < vsg_pkg::LN_A_LAST) c = vsg_pkg::LC_FV;
    else if (n == vsg_pkg::LN_A_LAST) c = vsg_pkg::LC_VE;
    else if (n <= vsg_pkg::LN_EQ3_END) c = vsg_pkg::LC_EQ;
    else if (n == vsg_pkg::LN_ES) c = vsg_pkg::LC_ES;
    else if (n <= vsg_pkg::LN_SY2_END) c = vsg_pkg::LC_SYNC;
    else if (n == vsg_pkg::LN_SE) c = vsg_pkg::LC_SE;
    else if (n <= vsg_pkg::LN_EQ4_END) c = vsg_pkg::LC_EQ;
    else if (n == vsg_pkg::LN_EB) c = vsg_pkg::LC_EB;
    else if (n <= vsg_pkg::LN_BB2_END) c = vsg_pkg::LC_BB;
    else if (n == vsg_pkg::LN_BV) c = vsg_pkg::LC_BV;
    return c;
  endfunction

  // field ends at 263 and 525; two-bit field wraps 3 to 0
  always_comb begin
    d = q;
    if (bus.resync) begin
      d.line = vsg_pkg::LN_VS_FIRST;
      d.field = 2'h0;
    end else if (bus.adv) begin
      d.line = q.line + 10'h001;
      if (q.line == vsg_pkg::LN_A_LAST) d.field = q.field + 2'h1;
      if (q.line == vsg_pkg::LN_B_LAST) begin
        d.line = vsg_pkg::LN_FIRST;
        d.field = q.field + 2'h1;
      end
    end
    d.code = code_of(d.line);
  end

  always_ff @(posedge clk) begin
    if (rst) q <= vsg_pkg::SEQ_RST;
    else q <= d;
  end

  assign bus.code = q.code;
  assign bus.field = q.field;
  assign bus.line = q.line;

  field_end_a: assert property (@(posedge clk) disable iff (rst)
    bus.adv && !bus.resync && q.line == vsg_pkg::LN_A_LAST
    |=> q.line == vsg_pkg::LN_A_LAST + 10'h001 && q.field == $past(q.field) + 2'h1)
    else $error("odd field did not hand over to even field");
  frame_wrap_a: assert property (@(posedge clk) disable iff (rst)
    bus.adv && !bus.resync && q.line == vsg_pkg::LN_B_LAST && q.field == 2'h3
    |=> q.line == vsg_pkg::LN_FIRST && q.field == 2'h0)
    else $error("four-field sequence did not wrap");
  sync_code_a: assert property (@(posedge clk) disable iff (rst)
    q.line >= vsg_pkg::LN_VS_FIRST && q.line <= vsg_pkg::LN_SY1_END
    |-> q.code == vsg_pkg::LC_SYNC)
    else $error("odd field sync lines miscoded");
  even_codes_a: assert property (@(posedge clk) disable iff (rst)
    (q.line == vsg_pkg::LN_ES |-> q.code == vsg_pkg::LC_ES) and
    (q.line == vsg_pkg::LN_EB |-> q.code == vsg_pkg::LC_EB) and
    (q.line == vsg_pkg::LN_BV |-> q.code == vsg_pkg::LC_BV))
    else $error("even field vertical lines miscoded");
endmodule

// [vsg_top.sv]
/*
  Video sync timing generator: APB timing registers, element sequencer
  and registered sync, blank and burst outputs.
  Assumes an APB master on CLK and sync pin inputs synchronous to CLK.
*/
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
module vsg_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // horizontal sync pin
  input wire logic HORIZONTAL_SYNC_PIN_N_I,
  output logic HORIZONTAL_SYNC_PIN_N_O,
  output logic HORIZONTAL_SYNC_PIN_OE_N,
  // vertical sync pin
  input wire logic VERTICAL_SYNC_PIN_N_I,
  output logic VERTICAL_SYNC_PIN_N_O,
  output logic VERTICAL_SYNC_PIN_OE_N,
  // timing outputs
  output logic PIXEL_CLOCK,
  output logic CSYNC_N,
  output logic BLANK_N,
  output logic BURST_GATE,
  output logic [vsg_pkg::CODE_W-1:0] LINE_CATEGORY_CODE,
  output logic [1:0] FIELD_SEQUENCE_CODE,
  output logic [vsg_pkg::LINE_W-1:0] LINE_NUM
);
  typedef struct packed {
    logic [vsg_pkg::NUM_TREG-1:0][vsg_pkg::LEN_W-1:0] treg;
    logic run;
    logic slave;
    logic [31:0] rdata;
    vsg_pkg::vsg_slot_t slot;
    logic [vsg_pkg::LEN_W-1:0] cnt;
    logic load;
    logic hs_n;
    logic vs_n;
    logic cs_n;
    logic blank_n;
    logic burst;
    logic chk;
    logic [vsg_pkg::LEN_W:0] cyc;
    logic [vsg_pkg::LEN_W:0] span;
  } vsg_top_st_t;

  vsg_top_st_t q;
  vsg_top_st_t d;

  vsg_seq_if seq_bus ();

  logic tick;
  logic hs_fall;
  logic vs_fall;
  logic hit;
  logic wr;
  logic step;
  logic restart;
  logic [31:0] rd;
  logic [4:0] ti;
  logic [2:0] idx;
  logic [vsg_pkg::LEN_W-1:0] ld;
  vsg_pkg::vsg_seg_t cur;

  // pixel phase and slave-mode edges
  vsg_pix_div u_div (
    .clk(CLK),
    .rst(RST),
    .hs_n(HORIZONTAL_SYNC_PIN_N_I),
    .vs_n(VERTICAL_SYNC_PIN_N_I),
    .tick(tick),
    .hs_fall(hs_fall),
    .vs_fall(vs_fall)
  );

  // line and field counting
  vsg_field_seq u_seq (
    .clk(CLK),
    .rst(RST),
    .bus(seq_bus.seq)
  );

  // slot number of the one-hot slot
  function automatic logic [2:0] idx_of(input vsg_pkg::vsg_slot_t s);
    logic [2:0] n;
    n = 3'h0;
    for (int k = 0; k < 8; k++) begin
      if (s[k]) n = 3'(k);
    end
    return n;
  endfunction

  // element table: length register and level of each slot of a line
  function automatic vsg_pkg::vsg_seg_t seg_of(input logic [4:0] code, input logic [2:0] i);
    vsg_pkg::vsg_seg_t s;
    logic lo_v;
    s.kind = vsg_pkg::K_BLANK;
    s.ridx = 5'(vsg_pkg::T_FP);
    s.last = 1'h0;
    lo_v = 1'h0;
    unique case (code)
      vsg_pkg::LC_EQ,
      vsg_pkg::LC_SYNC,
      vsg_pkg::LC_ES,
      vsg_pkg::LC_SE,
      vsg_pkg::LC_EB: begin
        // four slots: low, high, low, high; broad line shapes like ES
        if (i[1]) begin
          lo_v = code != vsg_pkg::LC_EQ && code != vsg_pkg::LC_SE;
        end else begin
          lo_v = code == vsg_pkg::LC_SYNC || code == vsg_pkg::LC_SE;
        end
        if (lo_v) begin
          s.ridx = i[0] ? 5'(vsg_pkg::T_SH) : 5'(vsg_pkg::T_SL);
        end else begin
          s.ridx = i[0] ? 5'(vsg_pkg::T_EH) : 5'(vsg_pkg::T_EL);
        end
        if (!i[0]) s.kind = lo_v ? vsg_pkg::K_VSLOW : vsg_pkg::K_EQLOW;
        s.last = i[1] && i[0];
      end
      default: begin
        // lines that open with a normal horizontal interval
        unique case (i)
          3'h0: s.ridx = 5'(vsg_pkg::T_FP);
          3'h1: begin
            s.kind = vsg_pkg::K_HSYNC;
            s.ridx = 5'(vsg_pkg::T_SY);
          end
          3'h2: s.ridx = 5'(vsg_pkg::T_BR);
          3'h3: begin
            s.kind = vsg_pkg::K_BURST;
            s.ridx = 5'(vsg_pkg::T_BU);
          end
          3'h4: begin
            if (code == vsg_pkg::LC_BV) s.ridx = 5'(vsg_pkg::T_XBP);
            else s.ridx = 5'(vsg_pkg::T_CBP);
          end
          3'h5: begin
            // blank line keeps burst but no picture
            if (code != vsg_pkg::LC_BB) s.kind = vsg_pkg::K_VIDEO;
            if (code == vsg_pkg::LC_BV) s.ridx = 5'(vsg_pkg::T_VB);
            else if (code == vsg_pkg::LC_VE) s.ridx = 5'(vsg_pkg::T_VC);
            else s.ridx = 5'(vsg_pkg::T_VA);
            s.last = code != vsg_pkg::LC_VE;
          end
          3'h6: begin
            s.kind = vsg_pkg::K_EQLOW;
            s.ridx = 5'(vsg_pkg::T_EL);
          end
          3'h7: begin
            s.ridx = 5'(vsg_pkg::T_EH);
            s.last = 1'h1;
          end
        endcase
      end
    endcase
    return s;
  endfunction

  // apb decode: whole words only; stray or misaligned addresses error
  always_comb begin
    hit = 1'h0;
    rd = 32'h0000_0000;
    ti = 5'(PADDR[7:2] - vsg_pkg::TREG_BASE[7:2]);
    if (PADDR == vsg_pkg::CTRL_OFS) begin
      hit = 1'h1;
      rd[vsg_pkg::CTRL_RUN_BIT] = q.run;
      rd[vsg_pkg::CTRL_SLAVE_BIT] = q.slave;
    end else if (PADDR == vsg_pkg::STAT_OFS) begin
      hit = 1'h1;
      rd = {15'h0000, seq_bus.field, seq_bus.code, seq_bus.line};
    end else if (PADDR >= vsg_pkg::TREG_BASE && PADDR < vsg_pkg::TREG_END
                 && PADDR[1:0] == 2'h0) begin
      hit = 1'h1;
      rd = {20'h00000, q.treg[ti]};
    end
  end

  // next state: registers, element sequencer, output levels
  always_comb begin
    d = q;
    step = 1'h0;
    seq_bus.adv = 1'h0;
    wr = PSEL && PENABLE && PWRITE && hit;
    restart = q.slave && hs_fall;
    seq_bus.resync = q.run && q.slave && vs_fall;
    idx = idx_of(q.slot);
    cur = seg_of(seq_bus.code, idx);
    ld = q.treg[cur.ridx];

    // read data caught in setup so the access needs no wait
    if (PSEL && !PENABLE) d.rdata = rd;
    if (wr && PADDR == vsg_pkg::CTRL_OFS) begin
      d.run = PWDATA[vsg_pkg::CTRL_RUN_BIT];
      d.slave = PWDATA[vsg_pkg::CTRL_SLAVE_BIT];
    end
    // new lengths take hold at the next element load
    if (wr && PADDR >= vsg_pkg::TREG_BASE) begin
      d.treg[ti] = PWDATA[vsg_pkg::LEN_W-1:0];
    end

    // element sequencer counted in pixel ticks
    if (!q.run) begin
      d.slot = vsg_pkg::SLOT0;
      d.load = 1'h1;
      d.cnt = '0;
    end else if (restart) begin
      d.slot = vsg_pkg::SLOT1;
      d.load = 1'h1;
      d.cnt = '0;
    end else if (q.load) begin
      // zero is taken as one pixel so the line never stalls
      d.load = 1'h0;
      d.cnt = (ld == '0) ? '0 : ld - 12'h001;
    end else if (tick && q.cnt == '0) begin
      step = 1'h1;
      d.load = 1'h1;
      if (cur.last) begin
        seq_bus.adv = 1'h1;
        d.slot = vsg_pkg::SLOT0;
      end else begin
        d.slot = vsg_pkg::vsg_slot_t'(8'(q.slot << 1));
      end
    end else if (tick) begin
      d.cnt = q.cnt - 12'h001;
    end

    // pin levels follow the element kind; vertical sync follows the slot's length register (T_SL or T_SH)
    d.cs_n = !(cur.kind == vsg_pkg::K_HSYNC || cur.kind == vsg_pkg::K_EQLOW
               || cur.kind == vsg_pkg::K_VSLOW);
    d.hs_n = !(cur.kind == vsg_pkg::K_HSYNC || (!d.cs_n && idx == 3'h0));
    d.vs_n = !(cur.ridx == 5'(vsg_pkg::T_SL) || cur.ridx == 5'(vsg_pkg::T_SH));
    d.blank_n = cur.kind == vsg_pkg::K_VIDEO;
    d.burst = cur.kind == vsg_pkg::K_BURST;
    // stopped generator parks the sync, blank and burst outputs at their idle levels
    if (!q.run) begin
      d.cs_n = 1'h1;
      d.hs_n = 1'h1;
      d.vs_n = 1'h1;
      d.blank_n = 1'h0;
      d.burst = 1'h0;
    end

    // element length watch, only between two clean steps
    if (step) begin
      d.chk = 1'h1;
      d.cyc = '0;
    end else begin
      d.cyc = q.cyc + 13'h0001;
    end
    if (q.load) d.span = (ld == '0) ? 13'h0002 : {ld, 1'h0};
    if (!q.run || restart) d.chk = 1'h0;
  end

  // one register stage for the whole state
  always_ff @(posedge CLK) begin
    if (RST) begin
      q <= '0;
      q.slot <= vsg_pkg::SLOT0;
      q.load <= 1'h1;
      q.hs_n <= 1'h1;
      q.vs_n <= 1'h1;
      q.cs_n <= 1'h1;
    end else begin
      q <= d;
    end
  end

  // apb answers in the first access cycle
  assign PREADY = 1'h1;
  assign PSLVERR = PSEL && PENABLE && !hit;
  assign PRDATA = q.rdata;

  // pins released in slave mode so the far source can drive them
  assign HORIZONTAL_SYNC_PIN_N_O = q.hs_n;
  assign HORIZONTAL_SYNC_PIN_OE_N = q.slave;
  assign VERTICAL_SYNC_PIN_N_O = q.vs_n;
  assign VERTICAL_SYNC_PIN_OE_N = q.slave;

  // timing outputs
  assign PIXEL_CLOCK = tick;
  assign CSYNC_N = q.cs_n;
  assign BLANK_N = q.blank_n;
  assign BURST_GATE = q.burst;
  assign LINE_CATEGORY_CODE = seq_bus.code;
  assign FIELD_SEQUENCE_CODE = seq_bus.field;
  assign LINE_NUM = seq_bus.line;

  // checks on the element sequencer
  sequence s_leave(sl);
    step && q.slot == sl;
  endsequence

  property p_next(sl, nx);
    @(posedge CLK) disable iff (RST) s_leave(sl) |=> q.slot == nx;
  endproperty

  elem_len_a: assert property (@(posedge CLK) disable iff (RST)
    step && q.chk |-> q.cyc + 13'h0001 == q.span)
    else $error("element did not last its count of pixels");
  pix_step_a: assert property (@(posedge CLK) disable iff (RST)
    step |-> tick ##1 !tick ##1 tick)
    else $error("element edge off the pixel grid");
  front_order_a: assert property (p_next(vsg_pkg::SLOT0, vsg_pkg::SLOT1))
    else $error("front porch not followed by sync");
  burst_order_a: assert property (p_next(vsg_pkg::SLOT3, vsg_pkg::SLOT4))
    else $error("burst not followed by back porch");
  line_end_a: assert property (@(posedge CLK) disable iff (RST)
    seq_bus.adv |-> cur.last ##1 q.slot == vsg_pkg::SLOT0 && q.load)
    else $error("line did not restart at front porch");
  sync_pair_a: assert property (@(posedge CLK) disable iff (RST)
    seq_bus.code == vsg_pkg::LC_SYNC && step && q.slot == vsg_pkg::SLOT3
    |-> seq_bus.adv)
    else $error("sync line not closed after two pulses");
  eq_pair_a: assert property (@(posedge CLK) disable iff (RST)
    seq_bus.code == vsg_pkg::LC_EQ && step && q.slot == vsg_pkg::SLOT1
    |-> !seq_bus.adv ##1 q.slot == vsg_pkg::SLOT2)
    else $error("equalization line ended after one pulse");
  xbp_use_a: assert property (@(posedge CLK) disable iff (RST)
    seq_bus.code == vsg_pkg::LC_BV && q.slot == vsg_pkg::SLOT4
    |-> cur.ridx == 5'(vsg_pkg::T_XBP) && cur.kind == vsg_pkg::K_BLANK)
    else $error("half-black line missing extended back porch");
  slave_hs_a: assert property (@(posedge CLK) disable iff (RST)
    q.run && q.slave && hs_fall |=> q.slot == vsg_pkg::SLOT1 && q.load)
    else $error("slave sync edge did not start sync interval");
  treg_wr_a: assert property (@(posedge CLK) disable iff (RST)
    wr && PADDR == vsg_pkg::TREG_BASE |=> q.treg[0] == $past(PWDATA[11:0]))
    else $error("timing register write lost");
endmodule

// [vsg_host_model.sv]
/*
  Host model: apb master that loads the timing registers.
  Assumes an apb slave clocked on clk.
*/
`timescale 1ns/10ps
module vsg_host_model (
  // clock
  input wire logic clk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // one transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // computed lengths in; the device does not derive the half-line segments
  task automatic load(input int fp, input int color_back_porch_len, input int va, input int sl, input int el);
    int c;
    int v;
    int h;
    int t[13];
    logic [31:0] r;
    logic e;
    c = color_back_porch_len - 5;
    v = va + 5;
    h = 4 * fp + c + v; // same length for fp, sync, gap and burst
    t = '{fp, fp, fp, fp, c, v, sl, h / 2 - sl, el, h / 2 - el, h / 2 - c, v - h / 2, 0};
    t[12] = v + c - t[10];
    for (int i = 0; i < 13; i++) xfer(1'b1, 8'(8'h08 + 4 * i), 32'(t[i]), r, e);
  endtask
endmodule

// [tb_top.sv]
/*
  Testbench: registers, two full four-field runs and slave resync.
  Assumes the host model drives apb and the bench the sync pins.
*/
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, err, ho, vo, hoe_n, voe_n;
  logic hs_x = 1'b1;
  logic vs_x = 1'b1;
  logic pclk, csync_n, blank_n, burst;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] code, pc;
  logic [1:0] fld, pf;
  logic [9:0] ln, pl, lnd;
  int fail_count = 0;
  int checks = 0;
  int cyc, nl, nb, nu, ticks;
  int nlines = 0;
  bit mon = 1'b0;
  // 24 clocks a line keeps the clock an even multiple of line rate
  always #25 clk = ~clk;
  vsg_top u_vsg_top (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HORIZONTAL_SYNC_PIN_N_I(hoe_n ? hs_x : ho), .HORIZONTAL_SYNC_PIN_N_O(ho),
    .HORIZONTAL_SYNC_PIN_OE_N(hoe_n), .VERTICAL_SYNC_PIN_N_I(voe_n ? vs_x : vo),
    .VERTICAL_SYNC_PIN_N_O(vo), .VERTICAL_SYNC_PIN_OE_N(voe_n), .PIXEL_CLOCK(pclk),
    .CSYNC_N(csync_n), .BLANK_N(blank_n), .BURST_GATE(burst), .LINE_CATEGORY_CODE(code),
    .FIELD_SEQUENCE_CODE(fld), .LINE_NUM(ln));
  vsg_host_model u_vsg_host_model (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  function automatic logic [4:0] ec(input int n);
    if (n <= 3 || (n >= 7 && n <= 9) || n == 264 || n == 265 || n == 270 || n == 271) return 5'h00;
    if (n <= 6 || n == 267 || n == 268) return 5'h03;
    if (n <= 20 || (n >= 273 && n <= 282)) return 5'h0D;
    if (n <= 262 || n >= 284) return 5'h0F;
    if (n == 263) return 5'h0C;
    if (n == 266) return 5'h01;
    if (n == 269) return 5'h02;
    if (n == 272) return 5'h10;
    return 5'h0E;
  endfunction
  // sync low, blank high and burst clocks per line for the lengths loaded below
  function automatic logic [23:0] shp(input logic [4:0] c);
    case (c)
      5'h00: return 24'h04_00_00;
      5'h03: return 24'h14_00_00;
      5'h0D: return 24'h02_00_02;
      5'h0F: return 24'h02_0E_02;
      5'h0E: return 24'h02_0A_02;
      5'h0C: return 24'h04_02_02;
      default: return 24'h0C_00_00;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic x(input logic w, input logic [7:0] a, input logic [31:0] d);
    u_vsg_host_model.xfer(w, a, d, rd, err);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, roughly the eight-field run plus margin
  always @(posedge clk) begin
    ticks++;
    if (ticks == 60000) begin
      fail_count++;
      complete_run();
    end
  end
  // per-line monitor; pin levels lag the line number by one clock, so windows
  // follow a delayed copy of it; the first two windows may be partial
  always @(posedge clk) begin
    if (mon && lnd !== pl) begin
      if (nlines > 1) begin
        chk(cyc, 24, "line period");
        chk({8'(nl), 8'(nb), 8'(nu)}, shp(pc), "line shape");
        chk(code, ec(ln), "line code");
        chk(ln, pl == 10'h20D ? 10'h001 : 10'(pl + 1), "next line");
        chk(fld, (pl == 10'h107 || pl == 10'h20D) ? 2'(pf + 1) : pf, "field");
      end
      nlines++;
      cyc = 0;
      nl = 0;
      nb = 0;
      nu = 0;
      pl = lnd;
      pc = code;
      pf = fld;
    end
    cyc++;
    nl += int'(csync_n === 1'b0);
    nb += int'(blank_n === 1'b1);
    nu += int'(burst === 1'b1);
    lnd = ln;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({hoe_n, voe_n, ho, vo, csync_n}, 32'h0000_0007, "pins after reset");
    x(1'b0, 8'h3C, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "spare reset");
    x(1'b1, 8'h3C, 32'hFFFF_FFFF);
    x(1'b0, 8'h3C, 32'h0000_0000);
    chk(rd, 32'h0000_0FFF, "spare readback");
    x(1'b0, 8'hF0, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped read");
    $display("test registers done");
    u_vsg_host_model.load(1, 6, 2, 5, 1);
    x(1'b1, 8'h00, 32'h0000_0001);
    mon = 1'b1;
    while (nlines < 2104) @(posedge clk);
    mon = 1'b0;
    $display("test field sequence done");
    x(1'b1, 8'h00, 32'h0000_0003);
    chk({hoe_n, voe_n}, 32'h0000_0003, "pins released");
    hs_x <= 1'b0;
    for (int i = 0; i < 8 && csync_n !== 1'b0; i++) @(posedge clk);
    chk(csync_n, 32'h0000_0000, "hs restart");
    vs_x <= 1'b0;
    for (int i = 0; i < 20 && ln !== 10'h004; i++) @(posedge clk);
    chk({fld, ln}, 32'h0000_0004, "vs resync");
    $display("test slave done");
    complete_run();
  end
endmodule
